// >>> rtl/tscm_core.sv
// tscm_core: sensor state, clock setting and channel mask registers with channel sequencer
// assumes decoded register commands from the serial front end, and per-channel
// touch and charge-level inputs from the analog front end
`timescale 1ns/1ns
module tscm_core
  import tscm_pkg::*;
#(
  parameter int CH = CHANNELS
)(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rstn,
  // decoded command port
  input  wire logic          cmdValid,
  input  wire logic [2:0]    cmdCode,
  input  wire logic [7:0]    cmdWrData,
  output logic [7:0]         cmdRdData,
  output logic               cmdRdValid,
  // configuration bits held elsewhere
  input  wire logic          maskPowerMode,
  input  wire logic          primaryMode,
  input  wire logic          secondaryMode,
  input  wire logic          regulatorOff,
  // cascade clock pins
  input  wire logic          extClkPin,
  output logic               clkOutPin,
  output logic               clkOutEn,
  // analog front end
  input  wire logic [CH-1:0] touchRaw,
  input  wire logic [CH-1:0] nearTarget,
  input  wire logic [CH-1:0] atTarget,
  input  wire logic          analogPorDone,
  output logic [CH-1:0]      sampleStrobe,
  output logic [CH-1:0]      fastCharge,
  output logic [CH-1:0]      fineCharge,
  output logic [CH-1:0]      countEnable,
  output logic               analogPowerOn,
  output logic               oscPowerOn
);
  import tscm_pkg::*;

  logic [7:0]    sensor_q;
  logic [7:0]    clock_q;
  logic [7:0]    mask_q;
  logic [7:0]    maskPrev_q;
  logic [2:0]    chanSel_q;
  logic [2:0]    extSync_q;
  logic          extLevel_q;
  logic          clkOut_q;
  logic          useExtClk;
  logic          tickSeen;
  logic [7:0]    rdData_d;
  logic [CH-1:0] startReq;
  tscm_start_t   startSt_q [CH];
  logic [3:0]    slotCnt_q [CH];
  tscm_tick_if   tickBus();
  logic [3*CH:0] anaSync1_q;
  logic [3*CH:0] anaSync2_q;
  logic [3*CH:0] anaSync3_q;
  logic [3*CH:0] anaLevel_q;
  logic [CH-1:0] touchLvl;
  logic [CH-1:0] nearLvl;
  logic [CH-1:0] atLvl;
  logic          porDoneLvl;

  // next enabled channel after cur; in normal power every channel counts
  function automatic logic [2:0] nextChan(input logic [2:0] cur, input logic [7:0] msk,
                                          input logic lowPower);
    logic [2:0] cand;
    nextChan = cur + 3'd1;
    for (int i = 1; i <= 8; i++) begin
      cand = 3'(cur + 3'(i));
      if (!lowPower || msk[cand]) begin
        nextChan = cand;
        break;
      end
    end
  endfunction : nextChan

  // clock setting register; bit 5 stored as written so reads echo it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clock_q <= CLOCK_RESET;
    end else if (cmdValid && cmdCode == CMD_WRITE_CLOCK) begin
      clock_q <= cmdWrData;
    end
  end

  // channel mask register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mask_q     <= MASK_RESET;
      maskPrev_q <= MASK_RESET;
    end else begin
      maskPrev_q <= mask_q;
      if (cmdValid && cmdCode == CMD_WRITE_MASK) begin
        mask_q <= cmdWrData;
      end
    end
  end

  // read path; registers live on the main supply, so reads work with analog off
  always_comb begin
    rdData_d = 8'h00;
    if (cmdCode == CMD_READ_SENSOR) begin
      rdData_d = sensor_q;
    end else if (cmdCode == CMD_READ_CLOCK) begin
      rdData_d = clock_q;
    end else if (cmdCode == CMD_READ_MASK) begin
      rdData_d = mask_q;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmdRdData  <= 8'h00;
      cmdRdValid <= 1'b0;
    end else begin
      cmdRdValid <= cmdValid && (cmdCode == CMD_READ_SENSOR || cmdCode == CMD_READ_CLOCK ||
                                 cmdCode == CMD_READ_MASK);
      if (cmdValid) begin
        cmdRdData <= rdData_d;
      end
    end
  end

  // external clock pin: three stages, level changes once stages two and three agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      extSync_q  <= 3'b000;
      extLevel_q <= 1'b0;
    end else begin
      extSync_q <= {extSync_q[1:0], extClkPin};
      if (extSync_q[1] == extSync_q[2]) begin
        extLevel_q <= extSync_q[2];
      end
    end
  end

  // analog levels come from the regulated domain: three stages, and a bit changes only
  // once stages two and three agree, so a comparator caught mid-swing is ignored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      anaSync1_q <= '0;
      anaSync2_q <= '0;
      anaSync3_q <= '0;
      anaLevel_q <= '0;
    end else begin
      anaSync1_q <= {analogPorDone, atTarget, nearTarget, touchRaw};
      anaSync2_q <= anaSync1_q;
      anaSync3_q <= anaSync2_q;
      anaLevel_q <= (anaSync3_q & ~(anaSync2_q ^ anaSync3_q)) |
                    (anaLevel_q & (anaSync2_q ^ anaSync3_q));
    end
  end
  assign touchLvl   = anaLevel_q[0 +: CH];
  assign nearLvl    = anaLevel_q[CH +: CH];
  assign atLvl      = anaLevel_q[2*CH +: CH];
  assign porDoneLvl = anaLevel_q[3*CH];

  assign useExtClk = clock_q[CLK_IN_BIT] || secondaryMode;

  tscm_clock_gen u_clock_gen (
    .mclk       (mclk),
    .rstn       (rstn),
    .oscTune    (clock_q[TUNE_LSB +: 3]),
    .coarseDiv  (clock_q[COARSE_LSB +: 2]),
    .useExtClk  (useExtClk),
    .extClkSync (extLevel_q),
    .tickPort   (tickBus.gen)
  );

  assign tickSeen   = tickBus.tick;
  assign oscPowerOn = tickBus.oscOn;

  // sample clock output toggles each internal tick, so its rising edge marks every second sample
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clkOut_q <= 1'b0;
    end else if (tickSeen) begin
      clkOut_q <= !clkOut_q;
    end
  end
  assign clkOutEn  = clock_q[CLK_OUT_BIT] || primaryMode;
  assign clkOutPin = clkOutEn && clkOut_q;

  // sequencer: one channel per internal tick, eight ticks per full round in normal power mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chanSel_q <= 3'd0;
    end else if (tickSeen) begin
      chanSel_q <= nextChan(chanSel_q, mask_q, maskPowerMode);
    end
  end

  // sample strobe; in low power mode a masked channel is never strobed
  always_comb begin
    sampleStrobe = '0;
    if (tickSeen && (!maskPowerMode || mask_q[chanSel_q])) begin
      sampleStrobe[chanSel_q] = 1'b1;
    end
  end

  // sensor state: masked channels still sampled in normal power mode but never reflected
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sensor_q <= SENSOR_RESET;
    end else if (tickSeen && mask_q[chanSel_q] && startSt_q[chanSel_q] == ST_RUN) begin
      sensor_q[chanSel_q] <= touchLvl[chanSel_q];
    end
  end

  // a rising mask bit restarts that channel
  assign startReq = mask_q & ~maskPrev_q;

  // per-channel start-up: fast charge, fine steps, then counters run
  for (genvar c = 0; c < CH; c++) begin : g_start
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        startSt_q[c] <= ST_IDLE;
        slotCnt_q[c] <= 4'h0;
      end else if (!porDoneLvl) begin
        startSt_q[c] <= ST_IDLE;
        slotCnt_q[c] <= 4'h0;
      end else if (startReq[c]) begin
        startSt_q[c] <= ST_FAST;
        slotCnt_q[c] <= 4'h0;
      end else begin
        case (startSt_q[c])
          ST_IDLE: begin
            startSt_q[c] <= ST_FAST;
            slotCnt_q[c] <= 4'h0;
          end
          ST_FAST: begin
            if (sampleStrobe[c]) begin
              slotCnt_q[c] <= slotCnt_q[c] + 4'h1;
              // leave fast charge when near target, or after a bounded time
              if (nearLvl[c] || slotCnt_q[c] >= FAST_SLOTS) begin
                startSt_q[c] <= ST_FINE;
                slotCnt_q[c] <= 4'h0;
              end
            end
          end
          ST_FINE: begin
            if (sampleStrobe[c] && (atLvl[c] || slotCnt_q[c] >= FINE_SLOTS)) begin
              startSt_q[c] <= ST_RUN;
            end else if (sampleStrobe[c]) begin
              slotCnt_q[c] <= slotCnt_q[c] + 4'h1;
            end
          end
          ST_RUN: begin
            startSt_q[c] <= ST_RUN;
          end
          default: begin
            startSt_q[c] <= ST_IDLE;
          end
        endcase
      end
    end
    assign fastCharge[c]  = startSt_q[c] == ST_FAST;
    assign fineCharge[c]  = startSt_q[c] == ST_FINE;
    assign countEnable[c] = startSt_q[c] == ST_RUN;
  end

  // regulator on unless the controller turned it off for an external supply
  assign analogPowerOn = !regulatorOff;
endmodule : tscm_core

// >>> rtl/tscm_pkg.sv
// tscm_pkg: shared constants and types for the touch sense clock and mask core
// assumes a single system clock domain and a decoded serial command interface upstream
package tscm_pkg;
  localparam int         CHANNELS        = 8;
  // command codes of the decoded serial command port (values chosen for this core)
  localparam logic [2:0] CMD_READ_SENSOR = 3'h1;
  localparam logic [2:0] CMD_WRITE_CLOCK = 3'h2;
  localparam logic [2:0] CMD_READ_CLOCK  = 3'h3;
  localparam logic [2:0] CMD_WRITE_MASK  = 3'h4;
  localparam logic [2:0] CMD_READ_MASK   = 3'h5;
  // clock setting fields
  localparam int         CLK_OUT_BIT     = 7;
  localparam int         CLK_IN_BIT      = 6;
  localparam int         UNUSED_BIT      = 5;
  localparam int         COARSE_LSB      = 3;
  localparam int         TUNE_LSB        = 0;
  // reset values
  localparam logic [7:0] SENSOR_RESET    = 8'h00;
  localparam logic [7:0] CLOCK_RESET     = 8'h0C;  // coarse 01, tuning 100
  localparam logic [7:0] MASK_RESET      = 8'hFF;
  // oscillator model: nominal period in mclk cycles, tuning scaled in eighths
  localparam logic [7:0] OSC_NOM_CYCLES  = 8'h08;
  // start-up charge phase lengths in sample slots
  localparam logic [3:0] FAST_SLOTS      = 4'h6;
  localparam logic [3:0] FINE_SLOTS      = 4'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_FAST, ST_FINE, ST_RUN} tscm_start_t;
endpackage : tscm_pkg

// >>> rtl/tscm_tick_if.sv
// tscm_tick_if: carries the internal sample tick from the clock generator to the core
// assumes both ends on mclk
`timescale 1ns/1ns
interface tscm_tick_if;
  logic tick;      // one-cycle internal clock pulse
  logic oscOn;     // internal oscillator powered
  modport gen  (output tick, output oscOn);
  modport user (input tick, input oscOn);
endinterface : tscm_tick_if

// >>> rtl/tscm_clock_gen.sv
// tscm_clock_gen: oscillator tuning, coarse divider and external clock selection
// assumes extClkSync is already synchronised to mclk
`timescale 1ns/1ns
module tscm_clock_gen
  import tscm_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // settings
  input  wire logic [2:0] oscTune,
  input  wire logic [1:0] coarseDiv,
  input  wire logic       useExtClk,
  input  wire logic       extClkSync,
  // tick out
  tscm_tick_if.gen        tickPort
);
  import tscm_pkg::*;

  logic [10:0] oscCnt_q;
  logic [5:0]  divCnt_q;
  logic        oscTick;
  logic        extPrev_q;
  logic [10:0] oscPeriod;
  logic [5:0]  divMax;

  // tuning 0.5..1.75 in steps; period scales inversely (period = nom*8/m8)
  function automatic logic [10:0] tunePeriod(input logic [2:0] code);
    logic [10:0] m8;
    m8 = (code < 3'd4) ? 11'(4 + code) : 11'(8 + 2 * (code - 3'd4));
    return 11'((OSC_NOM_CYCLES * 11'd8) / m8);
  endfunction : tunePeriod

  assign oscPeriod = tunePeriod(oscTune);
  // 00 -> 64, 01 -> 16, 10 -> 4, 11 -> 1
  assign divMax = (coarseDiv == 2'b00) ? 6'd63 : (coarseDiv == 2'b01) ? 6'd15 :
                  (coarseDiv == 2'b10) ? 6'd3 : 6'd0;

  // oscillator stops when the external clock is selected, saving power
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oscCnt_q <= '0;
    end else if (useExtClk) begin
      oscCnt_q <= '0;
    end else if (oscCnt_q >= oscPeriod - 11'd1) begin
      oscCnt_q <= '0;
    end else begin
      oscCnt_q <= oscCnt_q + 11'd1;
    end
  end
  assign oscTick = !useExtClk && (oscCnt_q >= oscPeriod - 11'd1);

  // coarse divider
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= '0;
    end else if (oscTick) begin
      divCnt_q <= (divCnt_q >= divMax) ? 6'd0 : divCnt_q + 6'd1;
    end
  end

  // external clock: inverted, so sampling happens on its falling edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= extClkSync;
    end
  end

  assign tickPort.tick  = useExtClk ? (extPrev_q && !extClkSync)
                                    : (oscTick && divCnt_q >= divMax);
  assign tickPort.oscOn = !useExtClk;
endmodule : tscm_clock_gen

// >>> verification/tscm_core_chk.sv
// tscm_core_chk: concurrent checks on the ports of tscm_core
// assumes one mclk domain; bound to the core from the bench top
`timescale 1ns/1ns
module tscm_core_chk
  import tscm_pkg::*;
#(
  parameter int CH = CHANNELS
)(
  // clock and reset
  input wire logic          mclk,
  input wire logic          rstn,
  // command port
  input wire logic          cmdValid,
  input wire logic [2:0]    cmdCode,
  input wire logic [7:0]    cmdWrData,
  input wire logic [7:0]    cmdRdData,
  input wire logic          cmdRdValid,
  // modes and clock pins
  input wire logic          maskPowerMode,
  input wire logic          primaryMode,
  input wire logic          secondaryMode,
  input wire logic          clkOutEn,
  input wire logic          clkOutPin,
  input wire logic          oscPowerOn,
  // channels
  input wire logic [CH-1:0] sampleStrobe,
  input wire logic [CH-1:0] fastCharge,
  input wire logic [CH-1:0] fineCharge,
  input wire logic [CH-1:0] countEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [7:0] maskQ;
  logic       isRead;
  assign isRead = cmdValid && (cmdCode inside {CMD_READ_SENSOR, CMD_READ_CLOCK, CMD_READ_MASK});
  // shadow of the mask, so read data and skipping are judged without the body
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      maskQ <= MASK_RESET;
    end else if (cmdValid && cmdCode == CMD_WRITE_MASK) begin
      maskQ <= cmdWrData;
    end
  end
  a_read_answer: assert property (isRead |=> cmdRdValid)
    else $error("read command got no answer");
  a_write_silent: assert property (cmdValid && !isRead |=> !cmdRdValid)
    else $error("write or unknown command answered");
  a_mask_echo: assert property (cmdValid && cmdCode == CMD_READ_MASK |=>
    cmdRdData == $past(maskQ)) else $error("mask read differs from last write");
  a_primary_out: assert property (primaryMode |-> clkOutEn)
    else $error("primary role without clock output");
  a_secondary_osc: assert property (secondaryMode |-> !oscPowerOn)
    else $error("secondary role with oscillator on");
  a_strobe_single: assert property ($onehot0(sampleStrobe))
    else $error("two channels strobed at once");
  // stale channel select right after a change is tolerated for eight cycles
  a_low_skip: assert property ($stable(maskQ) [*8] ##0 maskPowerMode [*8] |->
    (sampleStrobe & ~maskQ[CH-1:0]) == '0) else $error("masked channel sampled");
  a_one_phase: assert property ((countEnable & fastCharge) == '0)
    else $error("counters on during fast charge");
  a_run_from_fine: assert property (
    (countEnable & ~$past(countEnable) & ~$past(fineCharge)) == '0)
    else $error("counters enabled without fine charge first");
  a_out_toggle: assert property (|sampleStrobe && clkOutEn ##1 clkOutEn |->
    $changed(clkOutPin)) else $error("enabled clock output missed a tick");
  c_read: cover property (isRead ##1 cmdRdValid);
  c_cascade: cover property (secondaryMode && |sampleStrobe);
  c_low: cover property (maskPowerMode && |sampleStrobe);
  c_run: cover property (countEnable == '1);
endmodule : tscm_core_chk

// >>> verification/tscm_ctrl_model.sv
// tscm_ctrl_model: system controller issuing decoded register commands
// assumes the core takes a command on the edge where cmdValid is high
`timescale 1ns/1ns
module tscm_ctrl_model
  import tscm_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // command port
  output logic            cmdValid,
  output logic [2:0]      cmdCode,
  output logic [7:0]      cmdWrData,
  input  wire logic [7:0] cmdRdData,
  input  wire logic       cmdRdValid,
  // supply choice
  output logic            regulatorOff
);
  logic [7:0] rdData;
  logic       rdSeen;
  // idle port at time zero, internal regulator in use
  initial begin
    cmdValid     = 1'b0;
    cmdCode      = 3'h0;
    cmdWrData    = 8'h00;
    regulatorOff = 1'b0;
  end
  // one command per call; the answer is taken one edge after the command
  task automatic issue(input logic [2:0] code, input logic [7:0] data);
    @(posedge mclk);
    cmdValid  <= 1'b1;
    cmdCode   <= code;
    cmdWrData <= (code == CMD_WRITE_CLOCK) ? (data & 8'hDF) : data;
    @(posedge mclk);
    cmdValid  <= 1'b0;
    cmdWrData <= ~data; // released data must not look like the last value
    @(posedge mclk);
    rdSeen = cmdRdValid;
    rdData = cmdRdData;
  endtask : issue
  // an external analog supply wants the regulator shut down
  task automatic set_supply(input logic ext);
    @(posedge mclk);
    regulatorOff <= ext;
  endtask : set_supply
endmodule : tscm_ctrl_model

// >>> verification/tscm_core_tb_top.sv
// tscm_core_tb_top: self-checking bench for the touch sense clock and mask core
// assumes tscm_ctrl_model drives commands; the port checker is bound below
`timescale 1ns/1ns
module tscm_core_tb_top;
  import tscm_pkg::*;
  logic       mclk, rstn, cmdValid, cmdRdValid, regulatorOff, maskPowerMode;
  logic       primaryMode, secondaryMode, extClkPin, analogPorDone;
  logic       clkOutEn, clkOutPin, oscPowerOn, analogPowerOn;
  logic [1:0] extDiv;
  logic [2:0] cmdCode;
  logic [7:0] cmdWrData, cmdRdData, touchRaw, nearTarget, atTarget;
  logic [7:0] sampleStrobe, fastCharge, countEnable;
  int         nErrors, numChecks, outRises, cnt[8];

  tscm_ctrl_model u_tscm_ctrl_model (.mclk, .cmdValid, .cmdCode, .cmdWrData, .cmdRdData,
    .cmdRdValid, .regulatorOff);
  tscm_core u_tscm_core (.mclk, .rstn, .cmdValid, .cmdCode, .cmdWrData, .cmdRdData,
    .cmdRdValid, .maskPowerMode, .primaryMode, .secondaryMode, .regulatorOff, .extClkPin,
    .clkOutPin, .clkOutEn, .touchRaw, .nearTarget, .atTarget, .analogPorDone,
    .sampleStrobe, .fastCharge, .fineCharge(), .countEnable, .analogPowerOn, .oscPowerOn);

  // system clock, and a free-running cascade clock for the secondary role; its period of
  // four cycles is slow enough for the core's three-stage synchroniser to follow
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    extDiv <= extDiv + 2'd1;
  end
  assign extClkPin = extDiv[1];

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  // read through the partner; keep masks bits that may read either way
  task automatic rd(input string what, input logic [2:0] code, input logic [7:0] keep,
                    input logic [7:0] exp);
    u_tscm_ctrl_model.issue(code, 8'h00);
    check({what, " valid"}, 8'h01, {7'h0, u_tscm_ctrl_model.rdSeen});
    check(what, exp & keep, u_tscm_ctrl_model.rdData & keep);
  endtask : rd
  // strobes per channel and rising edges of the sample clock output over a window
  task automatic count_strobes(input int cycles);
    logic prevOut;
    cnt = '{default: 0};
    outRises = 0;
    prevOut = clkOutPin;
    repeat (cycles) begin
      @(posedge mclk);
      for (int i = 0; i < 8; i++) cnt[i] += (sampleStrobe[i] === 1'b1);
      outRises += (clkOutPin === 1'b1 && prevOut === 1'b0);
      prevOut = clkOutPin;
    end
  endtask : count_strobes
  task automatic test_done();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic t_reset();
    rd("sensor", CMD_READ_SENSOR, 8'hFF, 8'h00);
    rd("clock", CMD_READ_CLOCK, 8'hDF, 8'h0C);
    rd("mask", CMD_READ_MASK, 8'hFF, 8'hFF);
    check("analog power", 8'h01, {7'h0, analogPowerOn});
  endtask : t_reset
  // every coarse code, tuning extremes, both switch bits, then cascade roles
  task automatic t_clock();
    logic [7:0] v [4] = '{8'hC0, 8'h8B, 8'h57, 8'h1C};
    foreach (v[i]) begin
      u_tscm_ctrl_model.issue(CMD_WRITE_CLOCK, v[i]);
      rd("clock", CMD_READ_CLOCK, 8'hDF, v[i]);
      check("clock out", {7'h0, v[i][7]}, {7'h0, clkOutEn});
      check("osc power", {7'h0, !v[i][6]}, {7'h0, oscPowerOn});
    end
    u_tscm_ctrl_model.set_supply(1'b1);
    primaryMode   <= 1'b1;
    secondaryMode <= 1'b1;
    @(posedge mclk);
    #1;
    check("primary out", 8'h01, {7'h0, clkOutEn});
    check("secondary osc", 8'h00, {7'h0, oscPowerOn});
    check("analog off", 8'h00, {7'h0, analogPowerOn});
    rd("clock kept", CMD_READ_CLOCK, 8'hDF, 8'h1C);
    u_tscm_ctrl_model.set_supply(1'b0);
    count_strobes(400);
    check("ext strobes", 8'h01, {7'h0, cnt[0] >= 8});
    check("out edges", 8'h01, {7'h0, outRises >= 40});
    primaryMode   <= 1'b0;
    secondaryMode <= 1'b0;
  endtask : t_clock
  // sensor state ignores writes and unknown codes
  task automatic t_mask();
    u_tscm_ctrl_model.issue(CMD_WRITE_MASK, 8'h0F);
    rd("mask", CMD_READ_MASK, 8'hFF, 8'h0F);
    for (int c = 0; c < 8; c++) begin
      if (c == 0 || c > 5) u_tscm_ctrl_model.issue(c[2:0], 8'hFF);
    end
    rd("sensor ro", CMD_READ_SENSOR, 8'hFF, 8'h00);
    rd("mask kept", CMD_READ_MASK, 8'hFF, 8'h0F);
  endtask : t_mask
  task automatic t_start();
    touchRaw      <= 8'hA5;
    nearTarget    <= 8'hFF;
    atTarget      <= 8'hFF;
    analogPorDone <= 1'b1;
    repeat (1000) @(posedge mclk);
    check("counters", 8'h0F, countEnable & 8'h0F);
    rd("masked sensor", CMD_READ_SENSOR, 8'hFF, 8'h05);
    nearTarget <= 8'h00;
    u_tscm_ctrl_model.issue(CMD_WRITE_MASK, 8'hFF);
    #1;
    check("restart fast", 8'hF0, fastCharge);
    check("kept counters", 8'h0F, countEnable);
    @(posedge mclk);
    nearTarget <= 8'hFF;
    repeat (1500) @(posedge mclk);
    check("all counters", 8'hFF, countEnable);
    rd("sensor", CMD_READ_SENSOR, 8'hFF, 8'hA5);
    u_tscm_ctrl_model.issue(3'h6, 8'h00);
    rd("sensor kept", CMD_READ_SENSOR, 8'hFF, 8'hA5);
  endtask : t_start
  // 640 cycles are 80 ticks at coarse code 11 and nominal tuning
  task automatic t_sample();
    maskPowerMode <= 1'b1;
    u_tscm_ctrl_model.issue(CMD_WRITE_MASK, 8'h0F);
    repeat (20) @(posedge mclk);
    count_strobes(640);
    for (int i = 0; i < 8; i++) begin
      check("low strobes", (i < 4) ? 8'd20 : 8'd0, 8'(cnt[i]));
    end
    check("out idle", 8'd0, 8'(outRises));
    maskPowerMode <= 1'b0;
    repeat (20) @(posedge mclk);
    count_strobes(640);
    for (int i = 0; i < 8; i++) check("strobes", 8'd10, 8'(cnt[i]));
  endtask : t_sample

  // reset for two cycles, then the scenarios in order
  initial begin
    {rstn, maskPowerMode, primaryMode, secondaryMode, extDiv, analogPorDone} = '0;
    {touchRaw, nearTarget, atTarget} = '0;
    nErrors = 0;
    numChecks = 0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_clock();
    t_mask();
    t_start();
    t_sample();
    test_done();
  end
  // watchdog well beyond the roughly 4300 cycles the scenarios need
  initial begin
    repeat (20000) @(posedge mclk);
    nErrors++;
    test_done();
  end
endmodule : tscm_core_tb_top

bind tscm_core tscm_core_chk #(.CH(CH)) u_tscm_core_chk (.mclk, .rstn, .cmdValid, .cmdCode,
  .cmdWrData, .cmdRdData, .cmdRdValid, .maskPowerMode, .primaryMode, .secondaryMode,
  .clkOutEn, .clkOutPin, .oscPowerOn, .sampleStrobe, .fastCharge, .fineCharge, .countEnable);
